// ==== core/bcs_sequencer.sv ====
// Bus cycle sequencer: T-states, pin timing, interrupt and halt entry
`timescale 1ns/10ps
// Operation
// - Port read uses memory read timing with port-or-memory select high.
// - Port read puts the port number on both address bytes.
// - Port read only as third cycle of an input instruction.
// - Memory store status: select 0, bit one 0, bit zero 1.
// - Write keeps low bus driven, data and write strobe from T2.
// - Ready low in T2 inserts wait states holding every output.
// - Write strobe rises in T3; address and data held through T3.
// - Port store uses memory store timing, select high, port doubled.
// - Interrupt inputs sampled two states before first cycle T1.
// - Lone maskable request with flag set clears flag, runs acknowledge.
// - Acknowledge is fetch-shaped, ack strobe instead of read, select 1.
// - Further bytes fetched by three-state acknowledge cycles.
// - Program counter not advanced during acknowledge cycles.
// - Acknowledged call pushes counter high then low, then jumps.
// - Pair add cycles two and three are idle: no read, latch, ready.
// - Restart or nonmaskable entry runs idle fetch, internal opcode.
// - Restart input rising edge sets a latch sampled late in instruction.
// - Reset always leaves halt for the reset state.
// - Interrupt accepted in halt clears flag and starts first cycle.
// - Hold during halt leaves halt only while hold lasts.
// - Halt samples the edge latch each state, exits next clock.
// - Address latch strobe is issued in T1 of every cycle except pair add idle cycles.
// - Memory read status: select 0, bit one 1, bit zero 0.
module bcs_sequencer
  import bcs_pkg::*;
#(
  parameter logic [7:0] NMI_VECTOR = 8'h00
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire bcs_req_s    i_req,
  input  wire logic        i_req_valid,
  output logic             o_req_take,
  output logic             o_req_refused,
  input  wire logic        i_ready,
  input  wire logic [7:0]  i_low_bus_in,
  output bcs_pins_s        o_pins,
  input  wire logic        i_hold,
  output logic             o_hold_ack,
  input  wire logic        i_nmi,
  input  wire logic        i_edge_restart,
  input  wire logic        i_edge_mask,
  input  wire logic        i_maskable_irq_request,
  input  wire logic        i_irq_on,
  input  wire logic        i_irq_off,
  input  wire logic [15:0] i_pc,
  input  wire logic [15:0] i_sp,
  output logic             o_cycle_done,
  output logic             o_pc_inc,
  output logic [7:0]       o_rdata,
  output logic             o_rdata_valid,
  output logic             o_pc_load,
  output logic [15:0]      o_pc_target,
  output bcs_irq_e         o_irq_taken,
  output logic [7:0]       o_vector,
  output logic             o_irq_enable_flag
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  bcs_state_e  state;
  bcs_state_e  next_state;
  bcs_req_s    cur;
  bcs_req_s    next_cur;
  bcs_pins_s   next_pins;
  bcs_attr_s   attr;
  bcs_irq_e    irq_kind;
  bcs_irq_e    next_irq_taken;
  logic [1:0]  push_cnt;
  logic [1:0]  next_push_cnt;
  logic        push_hi;
  logic        cycle_end;
  logic        go_t3;
  logic        launch;
  logic        start_push;
  logic        sample;
  logic        accept;
  logic        irq_pending;
  logic        edge_latched;
  logic        ack_second;
  logic        next_ack_second;
  logic [7:0]  next_rdata;
  logic        next_rdata_valid;
  logic        next_pc_load;
  logic [15:0] next_pc_target;
  logic [7:0]  next_vector;

  // Pin image of a state within a cycle; registered so pins are glitch free
  function automatic bcs_pins_s pins_for(input bcs_state_e st,
                                         input bcs_req_s   r);
    bcs_pins_s   p;
    bcs_attr_s   a;
    logic [15:0] ad;
    p  = PINS_FLOAT;
    a  = bcs_attr(r.kind);
    ad = (r.kind == MC_PORT_RD || r.kind == MC_PORT_WR) ?
         {r.port, r.port} : r.addr;
    case (st)
      ST_T1, ST_T2, ST_TW, ST_T3, ST_T4: begin
        p.io_m            = a.io_m;
        p.status_bit_one  = a.s_one;
        p.status_bit_zero = a.s_zero;
        p.up_out          = ad[15:8];
        p.up_oe           = 1'b1;
        p.low_out         = ad[7:0];
      end
      default: begin
        p = PINS_FLOAT;
      end
    endcase
    case (st)
      ST_T1: begin
        p.ale    = a.ale;
        p.low_oe = 1'b1;
      end
      ST_T2, ST_TW: begin
        p.rd_n  = !a.rd;
        p.wr_n  = !a.wr;
        p.ack_n = !a.ack;
      end
      ST_T3: begin
        p.rd_n  = !a.rd;
        p.ack_n = !a.ack;
      end
      default: begin
        p.ale = 1'b0;
      end
    endcase
    // Write data stays on the low byte through T3, the last state of the cycle
    if (a.wr && (st == ST_T2 || st == ST_TW || st == ST_T3)) begin
      p.low_out = r.wdata;
      p.low_oe  = 1'b1;
    end
    return p;
  endfunction

  // ------------------------------------------------------------
  // Interrupt sampling and entry
  // ------------------------------------------------------------
  bcs_edge_latch u_edge (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_edge_restart),
    .i_clear   (accept && irq_kind == IRQ_EDGE),
    .o_latched (edge_latched)
  );

  bcs_irq_ctrl u_irq (
    .i_sys_clk              (i_sys_clk),
    .i_resetn               (i_resetn),
    .i_sample               (sample),
    .i_accept               (accept),
    .i_irq_on               (i_irq_on),
    .i_irq_off              (i_irq_off),
    .i_nmi                  (i_nmi),
    .i_edge_latched         (edge_latched),
    .i_edge_mask            (i_edge_mask),
    .i_maskable_irq_request (i_maskable_irq_request),
    .o_pending              (irq_pending),
    .o_kind                 (irq_kind),
    .o_irq_enable_flag      (o_irq_enable_flag)
  );

  // Cycle shape decode and timing points
  assign attr       = bcs_attr(cur.kind);
  assign go_t3      = !attr.rdy || i_ready;
  assign cycle_end  = (state == ST_T4) || (state == ST_T3 && !attr.four);
  assign start_push = cycle_end && cur.kind == MC_ACK_MORE && cur.push_pc;
  assign push_hi    = start_push || push_cnt == PUSH_STEPS;
  assign launch     = cycle_end || state == ST_IDLE ||
                      (state == ST_HALT && irq_pending && !i_hold);
  // Sample in the state before the last one of an instruction, or in halt
  assign sample = (state == ST_HALT) || (cur.last &&
                  ((state == ST_T3 && attr.four) ||
                   ((state == ST_T2 || state == ST_TW) && !attr.four &&
                    go_t3)));
  assign o_cycle_done = cycle_end;
  // Fetch advances the counter, acknowledge never does
  assign o_pc_inc     = cycle_end && cur.kind == MC_FETCH;
  assign o_hold_ack   = (state == ST_HOLD);

  // ------------------------------------------------------------
  // T-state sequencing and cycle launch
  // ------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_cur      = cur;
    next_push_cnt = push_cnt;
    o_req_take    = 1'b0;
    o_req_refused = 1'b0;
    accept        = 1'b0;
    case (state)
      ST_RESET: next_state = ST_IDLE;
      ST_T1:    next_state = ST_T2;
      ST_T2, ST_TW: begin
        next_state = go_t3 ? ST_T3 : ST_TW;
      end
      ST_T3: begin
        if (attr.four) begin
          next_state = ST_T4;
        end
      end
      ST_HALT: begin
        if (i_hold) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!i_hold) begin
          next_state = ST_HALT;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (launch) begin
      next_state = ST_IDLE;
      if (start_push || push_cnt != 2'h0) begin
        // Stack pushes of the interrupted counter, high byte first
        next_push_cnt    = (start_push ? PUSH_STEPS : push_cnt) - 2'h1;
        next_cur.kind    = MC_MEM_WR;
        next_cur.push_pc = 1'b1;
        next_cur.last    = 1'b0;
        next_cur.addr    = i_sp - (push_hi ? PUSH_HI_OFS : PUSH_LO_OFS);
        next_cur.wdata   = push_hi ? i_pc[15:8] : i_pc[7:0];
        next_state       = ST_T1;
      end else if (irq_pending && (state == ST_HALT ||
                   (i_req_valid && i_req.mc_index == MC_INDEX_FIRST))) begin
        // Interrupt replaces the first cycle of the next instruction
        accept            = 1'b1;
        next_cur          = '0;
        next_cur.kind     = (irq_kind == IRQ_MASK) ?
                            MC_ACK_FIRST : MC_IDLE_RST;
        next_cur.addr     = i_pc;
        next_cur.mc_index = MC_INDEX_FIRST;
        next_state        = ST_T1;
      end else if (state != ST_HALT && i_req_valid) begin
        o_req_take = 1'b1;
        if (i_req.kind == MC_HALT) begin
          next_state = ST_HALT;
        end else if (i_req.kind == MC_PORT_RD &&
                     i_req.mc_index != MC_INDEX_PORT_RD) begin
          o_req_refused = 1'b1;
        end else begin
          next_cur   = i_req;
          next_state = ST_T1;
        end
      end
    end
    next_pins = pins_for(next_state, next_cur);
  end

  // Reset is the one exit from halt that needs no clock
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state    <= ST_RESET;
      cur      <= '0;
      push_cnt <= 2'h0;
      o_pins   <= PINS_FLOAT;
    end else begin
      state    <= next_state;
      cur      <= next_cur;
      push_cnt <= next_push_cnt;
      o_pins   <= next_pins;
    end
  end

  // ------------------------------------------------------------
  // Read data, acknowledge bytes and counter reload
  // ------------------------------------------------------------
  always_comb begin
    next_rdata       = o_rdata;
    next_rdata_valid = 1'b0;
    next_pc_target   = o_pc_target;
    next_ack_second  = ack_second;
    next_vector      = o_vector;
    next_irq_taken   = accept ? irq_kind : IRQ_NONE;
    // Data is taken at the end of T3 while the strobe is still low
    if (state == ST_T3 && (attr.rd || attr.ack)) begin
      next_rdata       = i_low_bus_in;
      next_rdata_valid = 1'b1;
    end
    if (state == ST_T3 && cur.kind == MC_IDLE_RST) begin
      next_rdata       = RESTART_OPCODE;
      next_rdata_valid = 1'b1;
    end
    if (cycle_end && cur.kind == MC_ACK_FIRST) begin
      next_ack_second = 1'b0;
    end
    // Second fetched byte is the low target, third the high
    if (cycle_end && cur.kind == MC_ACK_MORE) begin
      if (ack_second) begin
        next_pc_target[15:8] = i_low_bus_in;
      end else begin
        next_pc_target[7:0] = i_low_bus_in;
      end
      next_ack_second = 1'b1;
    end
    next_pc_load = cycle_end && cur.kind == MC_MEM_WR && cur.push_pc &&
                   push_cnt == 2'h0;
    if (accept && irq_kind == IRQ_EDGE) begin
      next_vector = EDGE_VECTOR;
    end
    if (accept && irq_kind == IRQ_NMI) begin
      next_vector = NMI_VECTOR;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata       <= 8'h00;
      o_rdata_valid <= 1'b0;
      o_pc_target   <= 16'h0000;
      o_pc_load     <= 1'b0;
      ack_second    <= 1'b0;
      o_vector      <= 8'h00;
      o_irq_taken   <= IRQ_NONE;
    end else begin
      o_rdata       <= next_rdata;
      o_rdata_valid <= next_rdata_valid;
      o_pc_target   <= next_pc_target;
      o_pc_load     <= next_pc_load;
      ack_second    <= next_ack_second;
      o_vector      <= next_vector;
      o_irq_taken   <= next_irq_taken;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence wr_strobe_s;
    state == ST_T2 && attr.wr;
  endsequence

  sequence wr_release_s;
    state == ST_T3 && o_pins.wr_n && o_pins.low_oe &&
    o_pins.low_out == cur.wdata;
  endsequence

  wr_data_strobe_a: assert property (
    wr_strobe_s |-> !o_pins.wr_n && o_pins.low_oe &&
                    o_pins.low_out == cur.wdata)
    else $error("write data or strobe missing in T2");
  wr_release_a: assert property (
    wr_strobe_s ##0 i_ready |=> wr_release_s ##1 state != ST_T4)
    else $error("write strobe or data wrong in T3");
  wait_insert_a: assert property (
    (state == ST_T2 && attr.rdy && !i_ready) |=> state == ST_TW)
    else $error("no wait state on low ready");
  wait_hold_a: assert property (
    state == ST_TW |-> $stable(o_pins))
    else $error("outputs moved during wait");
  port_dup_a: assert property (
    (state == ST_T1 && cur.kind inside {MC_PORT_RD, MC_PORT_WR}) |->
    o_pins.low_out == o_pins.up_out && o_pins.io_m)
    else $error("port number not doubled");
  memwr_status_a: assert property (
    (state == ST_T1 && cur.kind == MC_MEM_WR) |->
    !o_pins.io_m && !o_pins.status_bit_one && o_pins.status_bit_zero)
    else $error("memory store status wrong");
  portrd_status_a: assert property (
    (state == ST_T1 && cur.kind == MC_PORT_RD) |->
    o_pins.io_m && o_pins.status_bit_one && !o_pins.status_bit_zero)
    else $error("port read status wrong");
  port_refuse_a: assert property (
    (o_req_take && i_req.kind == MC_PORT_RD &&
     i_req.mc_index != MC_INDEX_PORT_RD) |=> state == ST_IDLE)
    else $error("port read started outside third cycle");
  ack_strobe_a: assert property (
    (state == ST_T2 && attr.ack) |->
    !o_pins.ack_n && o_pins.rd_n && o_pins.io_m)
    else $error("acknowledge strobe wrong");
  ack_no_inc_a: assert property (
    (cycle_end && attr.ack) |-> !o_pc_inc)
    else $error("counter advanced in acknowledge");
  idle_add_a: assert property (
    (cur.kind == MC_IDLE_ADD && state inside {ST_T1, ST_T2, ST_T3}) |->
    o_pins.rd_n && !o_pins.ale)
    else $error("pair add idle cycle strobed");
  ale_t1_a: assert property (
    (state == ST_T1 && cur.kind != MC_IDLE_ADD) |-> o_pins.ale)
    else $error("address latch strobe missing");
  strobe_window_a: assert property (
    (!o_pins.rd_n || !o_pins.wr_n) |-> state inside {ST_T2, ST_TW, ST_T3})
    else $error("strobe outside T2 or T3");
  halt_exit_a: assert property (
    (state == ST_HALT && irq_pending && !i_hold) |=>
    state == ST_T1 && o_pins.ale && !o_irq_enable_flag)
    else $error("halt not left on interrupt");
  hold_return_a: assert property (
    (state == ST_HOLD && !i_hold) |=> state == ST_HALT)
    else $error("hold did not return to halt");

endmodule

// ==== core/bcs_pkg.sv ====
// Shared types, constants and cycle decoding of the bus cycle sequencer
package bcs_pkg;

  // ------------------------------------------------------------
  // Machine cycle kinds, sequencer states, interrupt classes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    MC_FETCH     = 4'h0,
    MC_MEM_RD    = 4'h1,
    MC_MEM_WR    = 4'h2,
    MC_PORT_RD   = 4'h3,
    MC_PORT_WR   = 4'h4,
    MC_ACK_FIRST = 4'h5,
    MC_ACK_MORE  = 4'h6,
    MC_IDLE_ADD  = 4'h7,
    MC_IDLE_RST  = 4'h8,
    MC_HALT      = 4'h9
  } bcs_kind_e;

  typedef enum logic [8:0] {
    ST_RESET = 9'h001,
    ST_IDLE  = 9'h002,
    ST_T1    = 9'h004,
    ST_T2    = 9'h008,
    ST_TW    = 9'h010,
    ST_T3    = 9'h020,
    ST_T4    = 9'h040,
    ST_HALT  = 9'h080,
    ST_HOLD  = 9'h100
  } bcs_state_e;

  typedef enum logic [1:0] {
    IRQ_NONE = 2'h0,
    IRQ_NMI  = 2'h1,
    IRQ_EDGE = 2'h2,
    IRQ_MASK = 2'h3
  } bcs_irq_e;

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam logic [2:0]  MC_INDEX_FIRST   = 3'h1;
  localparam logic [2:0]  MC_INDEX_PORT_RD = 3'h3;
  localparam logic [7:0]  EDGE_VECTOR      = 8'h3C;
  localparam logic [7:0]  RESTART_OPCODE   = 8'hFF;
  localparam logic [15:0] PUSH_HI_OFS      = 16'h0001;
  localparam logic [15:0] PUSH_LO_OFS      = 16'h0002;
  localparam logic [1:0]  PUSH_STEPS       = 2'h2;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    bcs_kind_e   kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  port;
    logic [2:0]  mc_index;
    logic        last;
    logic        push_pc;
  } bcs_req_s;

  typedef struct packed {
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       ack_n;
    logic       io_m;
    logic       status_bit_one;
    logic       status_bit_zero;
    logic [7:0] low_out;
    logic       low_oe;
    logic [7:0] up_out;
    logic       up_oe;
  } bcs_pins_s;

  typedef struct packed {
    logic io_m;
    logic s_one;
    logic s_zero;
    logic rd;
    logic wr;
    logic ack;
    logic ale;
    logic rdy;
    logic four;
  } bcs_attr_s;

  // Bus fully released, active-low strobes idle high, address latch strobe low
  localparam bcs_pins_s PINS_FLOAT = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
    ack_n: 1'b1, io_m: 1'b0, status_bit_one: 1'b0, status_bit_zero: 1'b0,
    low_out: 8'h00, low_oe: 1'b0, up_out: 8'h00, up_oe: 1'b0};

  // Per-kind status, strobes and length of a machine cycle
  function automatic bcs_attr_s bcs_attr(input bcs_kind_e k);
    bcs_attr_s a;
    a        = '0;
    a.ale    = (k != MC_IDLE_ADD);
    a.rdy    = (k != MC_IDLE_ADD) && (k != MC_IDLE_RST);
    a.four   = (k == MC_FETCH) || (k == MC_ACK_FIRST) || (k == MC_IDLE_RST);
    a.rd     = (k == MC_FETCH) || (k == MC_MEM_RD) || (k == MC_PORT_RD);
    a.wr     = (k == MC_MEM_WR) || (k == MC_PORT_WR);
    a.ack    = (k == MC_ACK_FIRST) || (k == MC_ACK_MORE);
    a.io_m   = (k == MC_PORT_RD) || (k == MC_PORT_WR) || a.ack;
    a.s_one  = !a.wr;
    a.s_zero = a.wr || a.ack || (k == MC_FETCH) || (k == MC_IDLE_RST);
    return a;
  endfunction

endpackage

// ==== core/bcs_edge_latch.sv ====
// Rising-edge catch latch for the edge-triggered restart input
`timescale 1ns/10ps
module bcs_edge_latch
  import bcs_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  input  wire logic i_clear,
  output logic      o_latched
);

  logic prev;
  logic next_prev;
  logic next_latched;

  // A new edge beats a clear in the same cycle
  always_comb begin
    next_prev    = i_pin;
    next_latched = o_latched;
    if (i_clear) begin
      next_latched = 1'b0;
    end
    if (i_pin && !prev) begin
      next_latched = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev      <= 1'b0;
      o_latched <= 1'b0;
    end else begin
      prev      <= next_prev;
      o_latched <= next_latched;
    end
  end

  edge_catch_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_pin && !prev) |=> o_latched)
    else $error("restart edge not caught");

endmodule

// ==== core/bcs_irq_ctrl.sv ====
// Interrupt enable flag, sampling and priority of pending requests
`timescale 1ns/10ps
module bcs_irq_ctrl
  import bcs_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_sample,
  input  wire logic i_accept,
  input  wire logic i_irq_on,
  input  wire logic i_irq_off,
  input  wire logic i_nmi,
  input  wire logic i_edge_latched,
  input  wire logic i_edge_mask,
  input  wire logic i_maskable_irq_request,
  output logic      o_pending,
  output bcs_irq_e  o_kind,
  output logic      o_irq_enable_flag
);

  logic s_nmi;
  logic s_edge;
  logic s_mask;
  logic next_s_nmi;
  logic next_s_edge;
  logic next_s_mask;
  logic next_ie;

  // Samples are frozen between strobes; acceptance clears them
  always_comb begin
    next_s_nmi  = s_nmi;
    next_s_edge = s_edge;
    next_s_mask = s_mask;
    next_ie     = o_irq_enable_flag;
    if (i_sample) begin
      next_s_nmi  = i_nmi;
      next_s_edge = i_edge_latched && o_irq_enable_flag && !i_edge_mask;
      next_s_mask = i_maskable_irq_request && o_irq_enable_flag;
    end
    if (i_accept) begin
      next_s_nmi  = 1'b0;
      next_s_edge = 1'b0;
      next_s_mask = 1'b0;
      next_ie     = 1'b0;
    end
    if (i_irq_off) begin
      next_ie = 1'b0;
    end
    if (i_irq_on) begin
      next_ie = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_nmi             <= 1'b0;
      s_edge            <= 1'b0;
      s_mask            <= 1'b0;
      o_irq_enable_flag <= 1'b0;
    end else begin
      s_nmi             <= next_s_nmi;
      s_edge            <= next_s_edge;
      s_mask            <= next_s_mask;
      o_irq_enable_flag <= next_ie;
    end
  end

  // Maskable wins only when nothing else is valid
  assign o_kind    = s_nmi ? IRQ_NMI : s_edge ? IRQ_EDGE :
                     s_mask ? IRQ_MASK : IRQ_NONE;
  assign o_pending = s_nmi || s_edge || s_mask;

  ie_cleared_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_accept && !i_irq_on) |=> !o_irq_enable_flag && !o_pending)
    else $error("enable flag kept after acceptance");

endmodule

// ==== verification/bcs_bus_partner.sv ====
// Far-side model: memory and ports
`timescale 1ns/10ps
module bcs_bus_partner
  import bcs_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire bcs_pins_s  i_pins,
  input  wire logic [7:0] i_data,
  input  wire logic [3:0] i_waits,
  output logic            o_ready,
  output logic [7:0]      o_bus
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] last = 8'h00;
  // Count states since the address strobe to stretch cycles
  always @(posedge i_sys_clk) begin
    cnt <= i_pins.ale ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
    last <= o_bus;
  end
  assign o_ready = (cnt >= i_waits);
  // Released bus toggles so a stale byte never looks valid
  assign o_bus = (!i_pins.rd_n || !i_pins.ack_n) ? i_data : ~last;
endmodule

// ==== verification/bcs_sequencer_test.sv ====
// Self-checking bench of the bus cycle sequencer
`timescale 1ns/10ps
module bcs_sequencer_test
  import bcs_pkg::*;
;
  logic i_sys_clk = 1'h0, i_resetn = 1'h0, vld = 1'h0, nmi = 1'h0;
  logic mreq = 1'h0, on = 1'h0, take, refused, ale, rdy, rv, flag;
  logic hold = 1'h0, hack, done, inc, pload;
  logic [2:0] flags;
  logic [1:0] taken;
  logic [7:0] pdata = 8'h00, pbus, rdata;
  logic [3:0] waits = 4'h0;
  logic [15:0] pc = 16'h0000, sp = 16'h0000, tgt, ptgt;
  bcs_req_s req = '0;
  bcs_pins_s pins;
  int err_total = 0;
  int compares = 0;
  bcs_kind_e kinds[5] = '{MC_MEM_WR, MC_PORT_WR, MC_PORT_RD, MC_MEM_RD,
    MC_IDLE_ADD};
  assign ale = pins.ale;
  assign flags = {done, ale, take};
  always #5 i_sys_clk = ~i_sys_clk;
  bcs_sequencer dut (.i_sys_clk, .i_resetn, .i_req(req), .i_req_valid(vld),
    .o_req_take(take), .o_req_refused(refused), .i_ready(rdy),
    .i_low_bus_in(pins.low_oe ? pins.low_out : pbus), .o_pins(pins),
    .i_hold(hold), .o_hold_ack(hack), .i_nmi(nmi), .i_edge_restart(1'h0),
    .i_edge_mask(1'h1), .i_maskable_irq_request(mreq), .i_irq_on(on),
    .i_irq_off(1'h0), .i_pc(pc), .i_sp(sp), .o_cycle_done(done),
    .o_pc_inc(inc), .o_rdata(rdata), .o_rdata_valid(rv), .o_pc_load(pload),
    .o_pc_target(ptgt), .o_irq_taken(taken), .o_vector(),
    .o_irq_enable_flag(flag));
  bcs_bus_partner far (.i_sys_clk, .i_pins(pins), .i_data(pdata),
    .i_waits(waits), .o_ready(rdy), .o_bus(pbus));
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // Bounded wait on take (0), ale (1) or cycle end (2); a hang ends the run
  task automatic wait_hi(int sel);
    int n;
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (flags[sel] !== 1'h1 && n < 40);
    if (flags[sel] !== 1'h1) begin
      err_total++;
      give_verdict();
    end
  endtask
  // One machine cycle, checked state by state
  task automatic cyc(bcs_kind_e k, logic [2:0] ix, logic lst);
    logic [15:0] a;
    logic [7:0] d;
    logic wr, rf, ba;
    logic [2:0] st;
    bcs_pins_s p2;
    a = 16'($urandom);
    d = 8'($urandom);
    wr = k inside {MC_MEM_WR, MC_PORT_WR};
    ba = (k == MC_IDLE_ADD);
    rf = (k == MC_PORT_RD) && (ix != 3'h3);
    st = wr ? 3'h1 : 3'h2;
    if (k inside {MC_PORT_RD, MC_PORT_WR}) begin
      a = {a[7:0], a[7:0]};
      st = st | 3'h4;
    end
    @(posedge i_sys_clk);
    req <= '{k, a, d, a[7:0], ix, lst, 1'h0};
    vld <= 1'h1;
    pdata <= d;
    wait_hi(0);
    chk("refused", refused, rf);
    @(posedge i_sys_clk);
    vld <= 1'h0;
    if (rf) return;
    @(negedge i_sys_clk);
    chk("ale", pins.ale, !ba);
    chk("status", {pins.io_m, pins.status_bit_one,
      pins.status_bit_zero}, st);
    chk("addr", {pins.up_out, pins.low_out}, a);
    @(negedge i_sys_clk);
    p2 = pins;
    chk("t2", {p2.rd_n, p2.wr_n}, {wr | ba, !wr});
    if (wr) chk("wdata", {p2.low_oe, p2.low_out}, {1'h1, d});
    repeat (ba ? 0 : waits) begin
      @(negedge i_sys_clk);
      chk("wait", pins, p2);
    end
    @(negedge i_sys_clk);
    chk("t3", {pins.rd_n, pins.wr_n, done}, {wr | ba, 2'h3});
    if (wr) chk("hold", pins.low_out, d);
    if (wr) return;
    @(negedge i_sys_clk);
    if (ba) chk("idle rv", rv, 1'h0);
    else chk("rdata", {rv, rdata}, {1'h1, d});
  endtask
  initial begin
    void'($urandom(32'hA3DD));
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'h1;
    for (int i = 0; i < 10; i++) begin
      @(posedge i_sys_clk);
      waits <= 4'($urandom % 3);
      cyc(kinds[i % 5], i == 2 ? 3'h1 : 3'h3, 1'h0);
      $display("test %0d done", i);
    end
    // Maskable request acknowledged at the end of an instruction
    @(posedge i_sys_clk);
    on <= 1'h1;
    mreq <= 1'h1;
    pc <= 16'($urandom);
    sp <= 16'($urandom);
    @(posedge i_sys_clk);
    on <= 1'h0;
    cyc(MC_MEM_RD, 3'h3, 1'h1);
    @(posedge i_sys_clk);
    req <= '{MC_FETCH, pc, 8'h00, 8'h00, 3'h1, 1'h1, 1'h0};
    vld <= 1'h1;
    pdata <= 8'($urandom);
    wait_hi(1);
    chk("taken", taken, IRQ_MASK);
    chk("ack st", {pins.io_m, pins.status_bit_one,
      pins.status_bit_zero}, 3'h7);
    chk("flag", flag, 1'h0);
    @(posedge i_sys_clk);
    vld <= 1'h0;
    mreq <= 1'h0;
    @(negedge i_sys_clk);
    chk("ack", {pins.ack_n, pins.rd_n}, 2'h1);
    repeat (2 + waits) @(negedge i_sys_clk);
    chk("opcode", {rv, rdata, done, inc},
      {1'h1, pdata, 2'h2});
    // Two call bytes, then the counter is pushed high byte first
    tgt = 16'h0000;
    for (int j = 0; j < 2; j++) begin
      @(posedge i_sys_clk);
      req <= '{MC_ACK_MORE, pc, 8'h00, 8'h00, 3'h2, 1'h0, 1'(j)};
      vld <= 1'h1;
      pdata <= 8'($urandom);
      wait_hi(0);
      @(posedge i_sys_clk);
      vld <= 1'h0;
      tgt = {pdata, tgt[15:8]};
      wait_hi(2);
      chk("more", {pins.ack_n, pins.io_m}, 2'h1);
    end
    for (int j = 0; j < 2; j++) begin
      wait_hi(1);
      chk("push a", {pins.io_m, pins.status_bit_one, pins.status_bit_zero,
        pins.up_out, pins.low_out}, {3'h1, sp - 16'(j + 1)});
      wait_hi(2);
      chk("push d", pins.low_out, j ? pc[7:0] : pc[15:8]);
    end
    @(negedge i_sys_clk);
    chk("call", {pload, ptgt}, {1'h1, tgt});
    $display("test ack done");
    // Halt left by a nonmaskable request
    @(posedge i_sys_clk);
    req <= '{MC_HALT, 16'h0000, 8'h00, 8'h00, 3'h1, 1'h0, 1'h0};
    vld <= 1'h1;
    wait_hi(0);
    @(posedge i_sys_clk);
    vld <= 1'h0;
    hold <= 1'h1;
    repeat (2) @(negedge i_sys_clk);
    chk("hold", hack, 1'h1);
    @(posedge i_sys_clk);
    hold <= 1'h0;
    nmi <= 1'h1;
    repeat (2) @(negedge i_sys_clk);
    chk("unhold", {hack, pins.up_oe}, 2'h0);
    wait_hi(1);
    chk("nmi", taken, IRQ_NMI);
    chk("idle st", {pins.io_m, pins.status_bit_one,
      pins.status_bit_zero}, 3'h3);
    @(negedge i_sys_clk);
    chk("no rd", pins.rd_n, 1'h1);
    repeat (2) @(negedge i_sys_clk);
    chk("rst op", {rv, rdata}, {1'h1, RESTART_OPCODE});
    $display("test halt done");
    give_verdict();
  end
endmodule
